// ===== src/scric_pkg.sv
// Shared constants and types of the clock, reset and interrupt controller
package scric_pkg;
  // Oscillator cycle counts
  localparam logic [12:0] POR_TIMEOUT_OSC  = 13'h1000;  // Power-on or low-voltage timeout
  localparam logic [12:0] STOP_LONG_OSC    = 13'h1000;  // Stop recovery, long option
  localparam logic [12:0] STOP_SHORT_OSC   = 13'h0800;  // Stop recovery, short option
  localparam logic [12:0] SHORT_RESET_OSC  = 13'h0020;  // Other reset sources
  localparam logic [12:0] PIN_GUARD_OSC    = 13'h0004;  // Pin ignored after own drive ends
  localparam logic [12:0] CNT_ONE          = 13'h0001;  // Unit step of the counter
  // Register byte offsets
  localparam logic [4:0]  OFS_OPTION       = 5'h00;     // Write-once option
  localparam logic [4:0]  OFS_RESET_STATUS = 5'h04;     // Reset sources seen
  localparam logic [4:0]  OFS_INT_STATUS   = 5'h08;     // Sticky events
  localparam logic [4:0]  OFS_INT_MASK     = 5'h0C;     // Event mask
  localparam logic [4:0]  OFS_WAIT_CLOCKS  = 5'h10;     // Clock sets kept in wait
  localparam logic [4:0]  OFS_STATE        = 5'h14;     // Live state
  // Field positions
  localparam int          OPT_STOP_SHORT   = 0;         // Option: short stop recovery
  localparam int          EV_RESET_DONE    = 0;         // Event: reset sequence ended
  localparam int          EV_STOP_DONE     = 1;         // Event: stop recovery ended
  localparam int          EV_WAIT_EXIT     = 2;         // Event: wait left
  // Reset values
  localparam logic [1:0]  OPTION_RST       = 2'h0;      // Option after reset
  localparam logic [1:0]  WAIT_CLOCKS_RST  = 2'h3;      // Both sets run in wait
  // Controller states
  typedef enum logic [2:0] {
    ST_RESET, ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER
  } scric_state_t;
  // Reset requests, one bit each, in reverse of the reset status register bit order
  typedef struct packed {
    logic low_voltage;
    logic usb;
    logic ill_address;
    logic ill_opcode;
    logic watchdog;
    logic pin;
    logic power_on;
  } scric_rst_src_t;
  // Avalon-MM request group
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } scric_avs_req_t;
endpackage : scric_pkg

// ===== src/scric_top.sv
// Clock gating, reset sequencing and interrupt arbitration of the system integration unit
// Operation
// RULE1 - Option register writable once per reset
// RULE2 - Bus clock is oscillator divided by two
// RULE3 - Clocks held 4096 cycles after power-on
// RULE4 - Reset pin driven low during timeout
// RULE5 - Bus clocks start when timeout completes
// RULE6 - Stop exit counts oscillator, clocks stay off
// RULE7 - Stop delay 4096 or 2048 per option
// RULE8 - Wait stops CPU, two clock sets remain
// RULE9 - Seven reset sources accepted
// RULE10 - Interrupts taken only at instruction end
// RULE11 - Take only unmasked and enabled interrupts
// RULE12 - Highest priority pending interrupt first
// RULE13 - Pending interrupt served after return first
// RULE14 - High index register never pushed
// RULE15 - Async reset requests synchronised first
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
module scric_top
  import scric_pkg::*;
(
  input  wire logic           i_clock,          // Oscillator clock
  input  wire logic           i_nrst,           // Synchronous reset, active low
  input  wire logic           i_clk_en,         // Freezes all state while low
  input  wire scric_rst_src_t i_rst_src,        // Asynchronous reset requests
  input  wire logic           i_stop_req,       // CPU executes stop
  input  wire logic           i_wait_req,       // CPU executes wait
  input  wire logic           i_wake,           // Interrupt or break wakeup
  input  wire logic           i_insn_bound,     // Instruction completes
  input  wire logic [7:0]     i_irq_pend,       // Pending hardware interrupts
  input  wire logic [7:0]     i_irq_en,         // Per-source enables
  input  wire logic           i_irq_mask,       // Global mask bit
  input  wire scric_avs_req_t i_avs,            // Avalon-MM request
  output logic [31:0]         o_avs_readdata,   // Avalon-MM read data
  output logic                o_avs_waitrequest,// Avalon-MM wait
  output logic                o_rst_pin_o,      // Reset pin level driven
  output logic                o_rst_pin_oe,     // Reset pin drive enable
  output logic                o_bus_clk_en,     // Internal bus clock enable
  output logic                o_cpu_clk_en,     // CPU clock enable
  output logic [1:0]          o_mod_clk_en,     // Two module clock sets
  output logic                o_int_take,       // Interrupt entry pulse
  output logic [2:0]          o_int_vec,        // Interrupt taken
  output logic                o_push_h,         // Push high index register
  output logic                o_irq             // Level interrupt
);

  // All state of the block
  typedef struct packed {
    scric_state_t   st;       // Sequencer state
    logic [12:0]    cnt;      // Delay counter
    logic           div;      // Bus clock phase
    logic [6:0]     sync1;    // First synchroniser stage
    logic [6:0]     sync2;    // Second synchroniser stage
    logic [1:0]     opt;      // Option bits
    logic           opt_lock; // Option written since reset
    logic [6:0]     rsr;      // Reset status
    logic [2:0]     ists;     // Sticky events
    logic [2:0]     imsk;     // Event mask
    logic [1:0]     wclk;     // Wait clock sets
    logic           ack;      // Bus answer cycle
    logic [31:0]    rdata;    // Read data
    logic           take;     // Interrupt entry
    logic [2:0]     vec;      // Interrupt number
  } scric_st_t;

  localparam scric_st_t ST_RST = '{
    st: ST_RESET, cnt: POR_TIMEOUT_OSC - CNT_ONE, div: 1'b0, sync1: 7'h00, sync2: 7'h00,
    opt: OPTION_RST, opt_lock: 1'b0, rsr: 7'h40, ists: 3'h0, imsk: 3'h0,
    wclk: WAIT_CLOCKS_RST, ack: 1'b0, rdata: 32'h0, take: 1'b0, vec: 3'h0};

  scric_st_t s;       // Current state
  scric_st_t next_s;  // Next state

  logic [6:0] src;    // Synchronised requests in status order
  logic       rst_any;// Any reset request
  logic       rst_long;// Request needs the long timeout
  logic [7:0] live;   // Enabled pending interrupts
  logic [2:0] pick;   // Highest priority live interrupt
  logic [2:0] ev;     // Events this cycle
  logic [31:0] rmux;  // Register read mux

  // Priority encoder, lowest number wins
  always_comb begin
    live = i_irq_pend & i_irq_en;
    pick = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (live[i]) begin
        pick = 3'(i); // RULE12
      end
    end
  end

  // Request qualification; pin is ignored while we drive it and just after
  always_comb begin
    src = {s.sync2[6:2], s.sync2[1] & (s.st != ST_RESET) & (s.cnt == 13'h0), s.sync2[0]};
    src = {src[0], src[1], src[2], src[3], src[4], src[5], src[6]};
    rst_any = |src; // RULE9
    rst_long = src[6] | src[0];
  end

  // Register read mux
  always_comb begin
    rmux = 32'h0;
    case (i_avs.address)
      OFS_OPTION:       rmux = {30'h0, s.opt};
      OFS_RESET_STATUS: rmux = {25'h0, s.rsr};
      OFS_INT_STATUS:   rmux = {29'h0, s.ists};
      OFS_INT_MASK:     rmux = {29'h0, s.imsk};
      OFS_WAIT_CLOCKS:  rmux = {30'h0, s.wclk};
      OFS_STATE:        rmux = {28'h0, s.opt_lock, s.st};
      default:          rmux = 32'h0;
    endcase
  end

  // Next state
  always_comb begin
    next_s = s;
    ev = 3'h0;
    next_s.take = 1'b0;
    next_s.sync1 = i_rst_src;          // RULE15
    next_s.sync2 = s.sync1;            // RULE15
    // Bus clock phase toggles only while the bus runs
    if (s.st == ST_RUN || s.st == ST_WAIT) begin
      next_s.div = ~s.div;             // RULE2
    end else begin
      next_s.div = 1'b0;
    end
    case (s.st)
      // Reset timeout, pin low, clocks held
      ST_RESET: begin
        if (s.cnt == 13'h0) begin
          next_s.st = ST_RUN;          // RULE5
          next_s.cnt = PIN_GUARD_OSC;
          ev[EV_RESET_DONE] = 1'b1;
        end else begin
          next_s.cnt = s.cnt - CNT_ONE; // RULE3
        end
      end
      // Normal execution
      ST_RUN: begin
        if (s.cnt != 13'h0) begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
        if (i_insn_bound && s.div && (live != 8'h0) && !i_irq_mask) begin
          next_s.take = 1'b1;          // RULE10 RULE11 RULE13
          next_s.vec = pick;
        end else if (i_stop_req && s.div) begin
          next_s.st = ST_STOP;
        end else if (i_wait_req && s.div) begin
          next_s.st = ST_WAIT;
        end
      end
      // CPU halted, module clocks per settings
      ST_WAIT: begin
        if (i_wake) begin
          next_s.st = ST_RUN;
          ev[EV_WAIT_EXIT] = 1'b1;
        end
      end
      // All clocks off
      ST_STOP: begin
        if (i_wake) begin
          next_s.st = ST_RECOVER;      // RULE6
          next_s.cnt = (s.opt[OPT_STOP_SHORT] ? STOP_SHORT_OSC : STOP_LONG_OSC) - CNT_ONE; // RULE7
        end
      end
      // Stop recovery count on the oscillator
      ST_RECOVER: begin
        if (s.cnt == 13'h0) begin
          next_s.st = ST_RUN;
          ev[EV_STOP_DONE] = 1'b1;
        end else begin
          next_s.cnt = s.cnt - CNT_ONE; // RULE6
        end
      end
      default: begin
        next_s.st = ST_RESET;
      end
    endcase
    // Any reset source restarts the sequence and reopens the option
    if (rst_any) begin
      next_s.st = ST_RESET;
      next_s.cnt = (rst_long ? POR_TIMEOUT_OSC : SHORT_RESET_OSC) - CNT_ONE; // RULE3
      next_s.rsr = src[6] ? 7'h40 : src; // RULE9
      next_s.opt = OPTION_RST;
      next_s.opt_lock = 1'b0;          // RULE1
      next_s.take = 1'b0;
    end
    // Bus slave: answer one cycle after the request
    next_s.ack = 1'b0;
    if ((i_avs.read || i_avs.write) && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = rmux;
    end
    if (i_avs.write && s.ack) begin
      case (i_avs.address)
        OFS_OPTION: begin
          if (!s.opt_lock && !rst_any) begin
            next_s.opt = i_avs.writedata[1:0]; // RULE1
            next_s.opt_lock = 1'b1;    // RULE1
          end
        end
        OFS_INT_STATUS:  next_s.ists = s.ists & ~i_avs.writedata[2:0];
        OFS_INT_MASK:    next_s.imsk = i_avs.writedata[2:0];
        OFS_WAIT_CLOCKS: next_s.wclk = i_avs.writedata[1:0];
        default:         next_s.ists = next_s.ists;
      endcase
    end
    // Set wins over clear
    next_s.ists = next_s.ists | ev;
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s <= ST_RST;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  // Outputs
  assign o_avs_readdata    = s.rdata;
  assign o_avs_waitrequest = ~s.ack;
  assign o_rst_pin_o       = 1'b0;
  assign o_rst_pin_oe      = (s.st == ST_RESET); // RULE4
  assign o_bus_clk_en      = s.div & (s.st == ST_RUN || s.st == ST_WAIT); // RULE2
  assign o_cpu_clk_en      = s.div & (s.st == ST_RUN); // RULE8
  assign o_mod_clk_en      = {2{s.div}} & ((s.st == ST_RUN) ? 2'h3 : (s.st == ST_WAIT) ? s.wclk : 2'h0); // RULE8
  assign o_int_take        = s.take;
  assign o_int_vec         = s.vec;
  assign o_push_h          = 1'b0;       // RULE14
  assign o_irq             = |(s.ists & s.imsk);

  // Helper: cycles spent in reset so far
  logic [12:0] rst_len;
  always_ff @(posedge i_clock) begin
    if (!i_nrst || s.st != ST_RESET) begin
      rst_len <= 13'h0;
    end else if (i_clk_en) begin
      rst_len <= rst_len + CNT_ONE;
    end
  end

  // Locked option never changes until a reset
  property p_opt_once;
    @(posedge i_clock) disable iff (!i_nrst)
    s.opt_lock && s.st != ST_RESET && !rst_any |=> $stable(s.opt) || s.st == ST_RESET;
  endproperty
  a_opt_once: assert property (p_opt_once) else $error("Option changed after lock"); // RULE1

  // Bus clock never on two enabled cycles running
  property p_half;
    @(posedge i_clock) disable iff (!i_nrst)
    o_bus_clk_en && i_clk_en |=> !o_bus_clk_en;
  endproperty
  a_half: assert property (p_half) else $error("Bus clock above half rate"); // RULE2

  // Leaving a power-on reset takes the full timeout
  property p_por_len;
    @(posedge i_clock) disable iff (!i_nrst)
    $fell(s.st == ST_RESET) && s.st == ST_RUN && s.rsr[6] |-> $past(rst_len) >= POR_TIMEOUT_OSC - CNT_ONE;
  endproperty
  a_por_len: assert property (p_por_len) else $error("Power-on timeout cut short"); // RULE3

  // Pin driven low whenever clocks are held in reset
  property p_pin;
    @(posedge i_clock) disable iff (!i_nrst)
    s.st == ST_RESET |-> o_rst_pin_oe && !o_rst_pin_o && !o_cpu_clk_en && !o_bus_clk_en;
  endproperty
  a_pin: assert property (p_pin) else $error("Reset pin not driven"); // RULE4

  // Recovery loads the selected delay
  property p_stop_dly;
    @(posedge i_clock) disable iff (!i_nrst)
    s.st == ST_STOP && i_wake && !rst_any && i_clk_en |=>
      s.cnt == (s.opt[OPT_STOP_SHORT] ? STOP_SHORT_OSC : STOP_LONG_OSC) - CNT_ONE;
  endproperty
  a_stop_dly: assert property (p_stop_dly) else $error("Wrong stop delay"); // RULE7

  // No CPU clock in stop, recovery or wait
  property p_cpu_off;
    @(posedge i_clock) disable iff (!i_nrst)
    s.st == ST_STOP || s.st == ST_RECOVER || s.st == ST_WAIT |-> !o_cpu_clk_en;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("CPU clock in low power"); // RULE6 RULE8

  // Entry only at a boundary with unmasked enabled request
  property p_take;
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(o_int_take) |-> $past(i_insn_bound) && !$past(i_irq_mask) && $past(live) != 8'h0;
  endproperty
  a_take: assert property (p_take) else $error("Interrupt taken illegally"); // RULE10 RULE11

  // Chosen vector is the highest priority one
  property p_prio;
    @(posedge i_clock) disable iff (!i_nrst)
    o_int_take |-> (($past(live) & (8'h01 << o_int_vec)) != 8'h0) &&
      (($past(live) & ((8'h01 << o_int_vec) - 8'h01)) == 8'h0);
  endproperty
  a_prio: assert property (p_prio) else $error("Priority order broken"); // RULE12 RULE13

  // High index register never stacked
  property p_noh;
    @(posedge i_clock) disable iff (!i_nrst)
    o_int_take |-> !o_push_h;
  endproperty
  a_noh: assert property (p_noh) else $error("High index pushed"); // RULE14

  // A synchronised request reaches reset within three cycles
  property p_sync;
    @(posedge i_clock) disable iff (!i_nrst)
    i_rst_src.watchdog && i_clk_en ##1 i_clk_en ##1 i_clk_en |=> s.st == ST_RESET;
  endproperty
  a_sync: assert property (p_sync) else $error("Reset request lost"); // RULE9 RULE15

endmodule : scric_top

// ===== verif/scric_cpu_model.sv
// CPU core model that reports instruction ends on the bus clock
`timescale 1ns/100ps
module scric_cpu_model (
  input  wire logic i_clock,      // Oscillator clock
  input  wire logic i_bus_clk_en, // Bus phase from the controller
  input  wire logic i_go,         // Run instructions
  output logic      o_insn_bound  // Instruction completes
);
  logic [1:0] phase = 2'h0;       // Bus cycles into the instruction
  // Every instruction lasts four bus cycles
  always_ff @(posedge i_clock) begin
    if (i_bus_clk_en) begin
      phase <= phase + 2'h1;
    end
  end
  // An end is only reported in a bus phase, where the controller samples it
  assign o_insn_bound = i_go & i_bus_clk_en & (phase == 2'h3);
endmodule : scric_cpu_model

// ===== verif/scric_top_tb.sv
// Self-checking bench of the clock, reset and interrupt controller
`timescale 1ns/100ps
module scric_top_tb;
  import scric_pkg::*;
  logic           i_clock = 1'b0;  // Oscillator clock
  logic           i_nrst  = 1'b0;  // Reset, active low
  scric_rst_src_t rst_src = '0;    // Reset requests
  logic           stop_req = 1'b0; // Stop request
  logic           wait_req = 1'b0; // Wait request
  logic           wake    = 1'b0;  // Wakeup
  logic           clk_en  = 1'b1;  // Clock enable
  logic           go      = 1'b0;  // CPU model runs
  logic           imask   = 1'b0;  // Global mask
  logic [7:0]     pend    = 8'h00; // Pending interrupts
  logic [7:0]     ien     = 8'h00; // Interrupt enables
  scric_avs_req_t avs     = '0;    // Bus request
  logic [31:0]    rdata;           // Read data taken
  logic [31:0]    avs_rd;          // Design read data
  logic           avs_wr;          // Design waitrequest
  logic           pin_o, pin_oe, bus_en, cpu_en, take, push_h, irq, bound;
  logic [1:0]     mod_en;          // Module clock sets
  logic [2:0]     vec;             // Vector taken
  int             num_errors = 0;  // Mismatches
  int             checked = 0;     // Comparisons
  int             cycles = 0;      // Timeout counter
  int             takes = 0;       // Interrupt entries seen
  int             pushes = 0;      // High index pushes seen
  logic [2:0]     first_vec;       // First vector taken
  // Clock of 100 ns
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  scric_top DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(clk_en), .i_rst_src(rst_src),
    .i_stop_req(stop_req), .i_wait_req(wait_req), .i_wake(wake), .i_insn_bound(bound),
    .i_irq_pend(pend), .i_irq_en(ien), .i_irq_mask(imask), .i_avs(avs), .o_avs_readdata(avs_rd),
    .o_avs_waitrequest(avs_wr), .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe), .o_bus_clk_en(bus_en),
    .o_cpu_clk_en(cpu_en), .o_mod_clk_en(mod_en), .o_int_take(take), .o_int_vec(vec),
    .o_push_h(push_h), .o_irq(irq));
  scric_cpu_model CPU (.i_clock(i_clock), .i_bus_clk_en(bus_en), .i_go(go), .o_insn_bound(bound));
  // Timeout and interrupt entry bookkeeping
  always @(posedge i_clock) begin
    cycles++;
    if (take === 1'b1) begin
      if (takes == 0) first_vec = vec;
      takes++;
    end
    if (push_h !== 1'b0) pushes++;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end
  // Compare one value
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    avs <= '{address: a, read: ~wr, write: wr, writedata: d};
    // Only the bench timeout ends this wait
    do begin
      @(posedge i_clock);
    end while (avs_wr !== 1'b0);
    q = avs_rd;
    avs <= '0;
  endtask : bus
  // Raise one reset source and measure the pin drive
  task automatic reset_by(input int i, input int lo);
    int n;
    n = 0;
    rst_src <= scric_rst_src_t'(7'(1 << i));
    @(posedge i_clock);
    rst_src <= '0;
    while (pin_oe !== 1'b1 && n < 20) begin
      @(posedge i_clock);
      n++;
    end
    n = 0;
    while (pin_oe === 1'b1 && n < 5000) begin
      @(posedge i_clock);
      n++;
    end
    check("reset length", 32'h1, {31'h0, n >= lo && n <= lo + 2});
    bus(1'b0, OFS_RESET_STATUS, 32'h0, rdata);
    check("reset source", 32'h40 >> i, rdata);
  endtask : reset_by
  // Stop, wake, and measure the recovery
  task automatic stop_for(input int lo);
    int n;
    n = 0;
    // Clear old events so the recovery event is seen fresh
    bus(1'b1, OFS_INT_STATUS, 32'h7, rdata);
    stop_req <= 1'b1;
    repeat (4) @(posedge i_clock);
    stop_req <= 1'b0;
    bus(1'b0, OFS_STATE, 32'h0, rdata);
    check("stop state", 32'h3, rdata & 32'h7);
    wake <= 1'b1;
    @(posedge i_clock);
    wake <= 1'b0;
    while (cpu_en !== 1'b1 && n < 5000) begin
      @(posedge i_clock);
      n++;
    end
    check("stop delay", 32'h1, {31'h0, n >= lo && n <= lo + 4});
    bus(1'b0, OFS_INT_STATUS, 32'h0, rdata);
    check("stop event", 32'h2, rdata & 32'h2);
  endtask : stop_for
  // Run the CPU model for a while with given interrupt inputs
  task automatic run_irq(input logic [7:0] p, input logic [7:0] e, input logic m);
    pend <= p;
    ien <= e;
    imask <= m;
    takes = 0;
    go <= 1'b1;
    repeat (40) @(posedge i_clock);
    go <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask : run_irq
  // Print the counts and the verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    int n;
    logic prev;
    logic [1:0] m0;
    n = 0;
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    check("pin level", 32'h0, {31'h0, pin_o});
    while (pin_oe === 1'b1 && n < 5000) begin
      check("bus held", 32'h0, {31'h0, bus_en});
      @(posedge i_clock);
      n++;
    end
    check("power-on length", 32'h1, {31'h0, n >= 4096 && n <= 4098});
    repeat (4) @(posedge i_clock);
    prev = bus_en;
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clock);
      check("bus clock", {31'h0, ~prev}, {31'h0, bus_en});
      check("cpu clock", {31'h0, bus_en}, {31'h0, cpu_en});
      check("run sets", {30'h0, bus_en, bus_en}, {30'h0, mod_en});
      prev = bus_en;
    end
    // Clock enable low freezes the bus phase
    clk_en <= 1'b0;
    repeat (2) @(posedge i_clock);
    prev = bus_en;
    repeat (3) @(posedge i_clock);
    check("frozen", {31'h0, prev}, {31'h0, bus_en});
    clk_en <= 1'b1;
    check("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, OFS_INT_MASK, 32'h7, rdata);
    @(posedge i_clock);
    check("irq on", 32'h1, {31'h0, irq});
    bus(1'b1, OFS_INT_STATUS, 32'h7, rdata);
    @(posedge i_clock);
    check("irq off", 32'h0, {31'h0, irq});
    bus(1'b0, 5'h1C, 32'h0, rdata);
    check("unmapped", 32'h0, rdata);
    for (int i = 0; i < 7; i++) begin
      reset_by(i, (i == 0 || i == 6) ? 4096 : 32);
    end
    repeat (8) @(posedge i_clock);
    stop_for(4096);
    bus(1'b1, OFS_OPTION, 32'h1, rdata);
    bus(1'b1, OFS_OPTION, 32'h0, rdata);
    bus(1'b0, OFS_OPTION, 32'h0, rdata);
    check("option once", 32'h1, rdata);
    stop_for(2048);
    bus(1'b1, OFS_WAIT_CLOCKS, 32'h1, rdata);
    bus(1'b1, OFS_INT_STATUS, 32'h7, rdata);
    wait_req <= 1'b1;
    repeat (4) @(posedge i_clock);
    wait_req <= 1'b0;
    repeat (6) @(posedge i_clock);
    m0 = mod_en;
    @(posedge i_clock);
    check("wait cpu", 32'h0, {31'h0, cpu_en});
    check("wait sets", 32'h1, {30'h0, mod_en | m0});
    wake <= 1'b1;
    @(posedge i_clock);
    wake <= 1'b0;
    repeat (8) @(posedge i_clock);
    bus(1'b0, OFS_INT_STATUS, 32'h0, rdata);
    check("wait event", 32'h4, rdata & 32'h4);
    run_irq(8'h0C, 8'hFF, 1'b0);
    check("first vector", 32'h2, {29'h0, first_vec});
    check("served again", 32'h1, {31'h0, takes > 1});
    run_irq(8'h0C, 8'hFF, 1'b1);
    check("masked", 32'h0, takes);
    run_irq(8'h0C, 8'h08, 1'b0);
    check("enabled only", 32'h3, {29'h0, first_vec});
    check("no index push", 32'h0, pushes);
    conclude();
  end
endmodule : scric_top_tb
